// >>> hw/ipm_ctrl.sv
/*
 * ipm_ctrl: six-source vectored interrupt controller with power mode logic.
 * assumes pins already synchronous to mclk; the core fetches vector bytes and
 * acknowledges each grant with one pulse; opcodes arrive as decode strobes.
 */
// Overview of operation
// - six maskable prioritised requests from pins, timers
// - mask register: global enable plus per-request bits
// - request zero: line two, vector 0/1
// - request one line three, three line zero, falling
// - request two: line one, vector 4/5
// - timers raise requests four and five, vectors 8-11
// - D7/D6 select edges for lines one, two
// - priority register orders the encoder
// - grant starts cycle, disables interrupts, saves state
// - vector is 16-bit from byte pair
// - request register records while masked, pollable
// - analog mode: comparators drive requests two, zero
// - analog mode: recovery source drives request one
// - one-shot reset delay on power, watchdog, stop
// - execution held until delay expires
// - halt gates cpu clock, peripherals stay active
// - halt ends on interrupt or reset
// - decode 6F stop, 7F halt after nop
// - stop halts oscillator, powers down comparators
// - stop ends on reset or recovery, restart
// - watchdog in stop forces delay
// - permanent watchdog on rc clock cannot be stopped
// - end of count raises timer request
// - recovery register bit five controls delay
`timescale 1ns/1ps
module ipm_ctrl
    import ipm_pkg::*;
#(
    parameter int POR_CYCLES = IPM_POR_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // pins and event sources
    input wire logic port3_line0,
    input wire logic port3_line1,
    input wire logic port3_line2,
    input wire logic port3_line3,
    input wire logic timer_zero_end,
    input wire logic timer_one_end,
    input wire logic first_analog_comparator,
    input wire logic second_analog_comparator,
    input wire logic analog_mode,
    input wire logic [7:0] recovery_lines,
    // reset causes and options
    input ipm_pkg::ipm_rst_src_t rst_src,
    input wire logic permanent_watchdog,
    input wire logic watchdog_rc_clock,
    input wire logic watchdog_stop_req,
    // core side
    input wire logic [7:0] op_code,
    input wire logic op_valid,
    input wire logic grant_ack,
    input wire logic int_reenable,
    output ipm_pkg::ipm_grant_t grant,
    output logic save_context,
    output logic cpu_clk_en,
    output logic osc_en,
    output logic comparator_en,
    output logic cpu_run,
    output logic restart,
    output logic watchdog_run
);
    import ipm_pkg::*;

    // a zero delay would leave the hold state with no count to run
    if (POR_CYCLES < 1) begin : g_bad_por
        $error("POR_CYCLES must be at least one");
    end

    logic [7:0] req_r, mask_r, prio_r, rec1_r, rec2_r;
    logic [3:0] prev_r;
    logic int_en_r;
    logic [31:0] por_cnt_r;
    logic last_op_nop_r;
    ipm_mode_t mode_r;
    logic [5:0] evt;
    logic [5:0] ack_clr;
    logic [5:0] active;
    logic [2:0] win;
    logic win_ok;
    logic [3:0] cur;
    logic rec_sel;
    logic any_rst;
    logic por_fire;

    // raw sources after analog remap
    always_comb begin
        cur[0] = analog_mode ? second_analog_comparator : port3_line2;
        cur[1] = analog_mode ? rec_sel : port3_line3;
        cur[2] = analog_mode ? first_analog_comparator : port3_line1;
        cur[3] = port3_line0;
    end

    // recovery source: second register overrides when nonzero
    always_comb begin
        if (rec2_r[1:0] != 2'b00) begin
            rec_sel = recovery_lines[{1'b0, rec2_r[1:0]} + 3'h3];
        end else begin
            rec_sel = recovery_lines[rec1_r[IPM_SRC_LO_BIT +: 3]];
        end
    end

    // edge qualification per request
    always_comb begin
        evt[0] = req_r[IPM_EDGE_L2_BIT]
                 ? (req_r[IPM_EDGE_L1_BIT] ? (cur[0] != prev_r[0]) : (~prev_r[0] & cur[0]))
                 : (prev_r[0] & ~cur[0]);
        evt[1] = prev_r[1] & ~cur[1];
        evt[2] = req_r[IPM_EDGE_L1_BIT]
                 ? (req_r[IPM_EDGE_L2_BIT] ? (cur[2] != prev_r[2]) : (~prev_r[2] & cur[2]))
                 : (prev_r[2] & ~cur[2]);
        evt[3] = prev_r[3] & ~cur[3];
        evt[4] = timer_zero_end;
        evt[5] = timer_one_end;
    end
    // note: 01 means line one falling, line two rising; 11 both edges on both

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prev_r <= 4'hF;
        end else begin
            prev_r <= cur;
        end
    end

    // active requests: pending and individually and globally enabled
    assign active = req_r[5:0] & mask_r[5:0] & {6{mask_r[IPM_GLOBAL_BIT] & int_en_r}};

    // priority encoder: prio_r[2:0] rotates the search start
    always_comb begin
        logic [2:0] idx;
        win = 3'd0;
        win_ok = 1'b0;
        idx = 3'd0;
        for (int k = IPM_NREQ - 1; k >= 0; k--) begin
            idx = 3'(({1'b0, prio_r[2:0]} + 4'(k)) % 4'd6);
            if (active[idx]) begin
                win = idx;
                win_ok = 1'b1;
            end
        end
    end

    assign ack_clr = (grant.valid && grant_ack) ? grant.src : 6'h00;

    // pending bits: set wins over clear, masked sources still record
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            req_r <= IPM_REQ_RST;
        end else begin
            if (reg_wr && reg_addr == IPM_ADDR_REQ) begin
                req_r <= {reg_wdata[7:6], 2'b00, reg_wdata[3:0]} & 8'hC0 | {2'b00, reg_wdata[5:0] | evt};
            end else begin
                req_r[5:0] <= (req_r[5:0] & ~ack_clr) | evt;
            end
        end
    end

    // configuration registers
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mask_r <= IPM_MASK_RST;
            prio_r <= IPM_PRIO_RST;
            rec1_r <= IPM_REC1_RST;
            rec2_r <= IPM_REC2_RST;
        end else if (reg_wr) begin
            if (reg_addr == IPM_ADDR_MASK) begin
                mask_r <= reg_wdata;
            end else if (reg_addr == IPM_ADDR_PRIO) begin
                prio_r <= reg_wdata;
            end else if (reg_addr == IPM_ADDR_REC1) begin
                rec1_r <= reg_wdata;
            end else if (reg_addr == IPM_ADDR_REC2) begin
                rec2_r <= {6'h00, reg_wdata[1:0]};
            end
        end
    end

    // grant: vector is 2*n as 16-bit address; held until the core acks
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            grant <= '0;
            save_context <= 1'b0;
            int_en_r <= 1'b1;
        end else begin
            save_context <= 1'b0;
            if (grant.valid) begin
                if (grant_ack) begin
                    grant <= '0;
                end
            end else if (win_ok && cpu_run) begin
                grant.valid <= 1'b1;
                grant.vec_addr <= {12'h000, win, 1'b0};
                grant.src <= 6'(1) << win;
                save_context <= 1'b1;
                int_en_r <= 1'b0;
            end else if (int_reenable) begin
                int_en_r <= 1'b1;
            end
        end
    end

    assign any_rst = rst_src.power_good | rst_src.watchdog | rst_src.low_voltage | rst_src.external;
    // one-shot fires on power good, watchdog, or stop recovery with delay
    assign por_fire = rst_src.power_good | rst_src.watchdog
                      | (mode_r == IPM_STOP && rec_sel && rec1_r[IPM_STOP_DLY_BIT]);

    // power mode machine
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            mode_r <= IPM_HOLD;
            por_cnt_r <= 32'(POR_CYCLES);
            restart <= 1'b0;
            last_op_nop_r <= 1'b0;
        end else begin
            restart <= 1'b0;
            if (op_valid) begin
                last_op_nop_r <= (op_code == IPM_OP_NOP);
            end
            if (por_fire) begin
                mode_r <= IPM_HOLD;
                por_cnt_r <= 32'(POR_CYCLES);
            end else begin
                case (mode_r)
                    IPM_HOLD: begin
                        if (por_cnt_r <= 32'd1) begin
                            mode_r <= IPM_RUN;
                            restart <= 1'b1;
                        end else begin
                            por_cnt_r <= por_cnt_r - 32'd1;
                        end
                    end
                    IPM_RUN: begin
                        if (op_valid && last_op_nop_r && op_code == IPM_OP_STOP) begin
                            mode_r <= IPM_STOP;
                        end else if (op_valid && last_op_nop_r && op_code == IPM_OP_HALT) begin
                            mode_r <= IPM_HALT;
                        end
                    end
                    IPM_HALT: begin
                        if (win_ok || any_rst) begin
                            mode_r <= IPM_RUN;
                            restart <= any_rst;
                        end
                    end
                    IPM_STOP: begin
                        if (any_rst || rec_sel) begin
                            mode_r <= IPM_RUN;
                            restart <= 1'b1;
                        end
                    end
                    default: mode_r <= IPM_HOLD;
                endcase
            end
        end
    end

    // mode outputs registered from the current mode_r, one cycle behind it
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cpu_clk_en <= 1'b0;
            osc_en <= 1'b1;
            comparator_en <= 1'b1;
            cpu_run <= 1'b0;
            watchdog_run <= 1'b1;
        end else begin
            cpu_clk_en <= (mode_r == IPM_RUN);
            cpu_run <= (mode_r == IPM_RUN);
            osc_en <= (mode_r != IPM_STOP);
            comparator_en <= (mode_r != IPM_STOP);
            watchdog_run <= (permanent_watchdog && watchdog_rc_clock) || !watchdog_stop_req;
        end
    end

    // read port: data in the cycle after the strobe
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            if (reg_addr == IPM_ADDR_REQ) begin
                reg_rdata <= req_r;
            end else if (reg_addr == IPM_ADDR_MASK) begin
                reg_rdata <= mask_r;
            end else if (reg_addr == IPM_ADDR_PRIO) begin
                reg_rdata <= prio_r;
            end else if (reg_addr == IPM_ADDR_REC1) begin
                reg_rdata <= rec1_r;
            end else if (reg_addr == IPM_ADDR_REC2) begin
                reg_rdata <= rec2_r;
            end else if (reg_addr == IPM_ADDR_STAT) begin
                reg_rdata <= {5'h00, int_en_r, mode_r};
            end else begin
                reg_rdata <= 8'h00;
            end
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // checks
    a_timer_pending: assert property (@(posedge mclk) disable iff (rst)
        timer_zero_end |=> req_r[4])
        else $error("timer zero end not recorded");
    a_masked_record: assert property (@(posedge mclk) disable iff (rst)
        (evt[1] && !mask_r[1] && !(reg_wr && reg_addr == IPM_ADDR_REQ)) |=> req_r[1])
        else $error("masked request lost");
    a_grant_vector: assert property (@(posedge mclk) disable iff (rst)
        grant.valid |-> grant.vec_addr == {12'h000, 3'(grant.src == 6'h02 ? 1 : grant.src == 6'h04 ? 2 :
            grant.src == 6'h08 ? 3 : grant.src == 6'h10 ? 4 : grant.src == 6'h20 ? 5 : 0), 1'b0})
        else $error("vector does not match source");
    a_grant_disables: assert property (@(posedge mclk) disable iff (rst)
        $rose(grant.valid) |-> !int_en_r && save_context)
        else $error("grant did not disable");
    a_global_mask: assert property (@(posedge mclk) disable iff (rst)
        !mask_r[IPM_GLOBAL_BIT] |=> !$rose(grant.valid))
        else $error("grant while globally masked");
    a_ack_clears: assert property (@(posedge mclk) disable iff (rst)
        (grant.valid && grant_ack && !(|(evt & grant.src)) && !(reg_wr && reg_addr == IPM_ADDR_REQ))
        |=> !(|(req_r[5:0] & $past(grant.src))))
        else $error("pending not cleared");
    a_stop_clocks: assert property (@(posedge mclk) disable iff (rst)
        mode_r == IPM_STOP |=> !osc_en && !comparator_en)
        else $error("stop left clocks on");
    a_hold_no_run: assert property (@(posedge mclk) disable iff (rst)
        mode_r == IPM_HOLD |=> !cpu_run)
        else $error("ran during reset delay");
    a_perm_watchdog: assert property (@(posedge mclk) disable iff (rst)
        (permanent_watchdog && watchdog_rc_clock) |=> watchdog_run)
        else $error("watchdog stopped");
    a_halt_exit: assert property (@(posedge mclk) disable iff (rst)
        (mode_r == IPM_HALT && win_ok && !por_fire) |=> mode_r == IPM_RUN)
        else $error("halt not left");
    // rising-only select must ignore a falling line two
    a_line_two_rise: assert property (@(posedge mclk) disable iff (rst)
        (req_r[7:6] == 2'b01 && prev_r[0] && !cur[0]) |-> !evt[0])
        else $error("falling edge taken in rising-only select");
    a_analog_remap: assert property (@(posedge mclk) disable iff (rst)
        (analog_mode && $past(analog_mode) && $changed(first_analog_comparator) && req_r[7:6] == 2'b11)
        |=> req_r[2])
        else $error("comparator event not raised as request two");
    a_sleep_needs_nop: assert property (@(posedge mclk) disable iff (rst)
        (mode_r == IPM_RUN && op_valid && !last_op_nop_r) |=> mode_r inside {IPM_RUN, IPM_HOLD})
        else $error("sleep entered without flush");
    a_stop_entry: assert property (@(posedge mclk) disable iff (rst)
        (mode_r == IPM_RUN && op_valid && last_op_nop_r && op_code == IPM_OP_STOP && !por_fire)
        |=> mode_r == IPM_STOP)
        else $error("stop not entered");
    a_stop_restart: assert property (@(posedge mclk) disable iff (rst)
        (mode_r == IPM_STOP && !por_fire && (any_rst || rec_sel)) |=> mode_r == IPM_RUN && restart)
        else $error("stop not left with restart");
    a_wd_stop_delay: assert property (@(posedge mclk) disable iff (rst)
        (mode_r == IPM_STOP && rst_src.watchdog) |=> mode_r == IPM_HOLD)
        else $error("watchdog in stop skipped the delay");
    a_hold_counts: assert property (@(posedge mclk) disable iff (rst)
        (mode_r == IPM_HOLD && por_cnt_r > 32'd1 && !por_fire) |=> mode_r == IPM_HOLD)
        else $error("reset delay cut short");
    a_grant_in_run: assert property (@(posedge mclk) disable iff (rst)
        $rose(grant.valid) |-> $past(cpu_run))
        else $error("grant issued while core clock stopped");
    a_pending_set: assert property (@(posedge mclk) disable iff (rst)
        (|evt) |=> (req_r[5:0] & $past(evt)) == $past(evt))
        else $error("qualified edge not recorded");
    c_grant: cover property (@(posedge mclk) disable iff (rst) $rose(grant.valid));
    c_halt_wake: cover property (@(posedge mclk) disable iff (rst) mode_r == IPM_HALT ##1 mode_r == IPM_RUN);
    c_stop_wake: cover property (@(posedge mclk) disable iff (rst) mode_r == IPM_STOP ##1 mode_r == IPM_RUN);
    c_stop_hold: cover property (@(posedge mclk) disable iff (rst) mode_r == IPM_STOP ##1 mode_r == IPM_HOLD);
    c_analog_event: cover property (@(posedge mclk) disable iff (rst) analog_mode && evt[1]);
endmodule : ipm_ctrl

// >>> inc/ipm_pkg.sv
/*
 * ipm_pkg: constants and carrier types for the interrupt and power mode block.
 * assumes a single 125 MHz clock domain and an 8-bit register port.
 */
package ipm_pkg;
    // register indices on the plain register port
    localparam logic [3:0] IPM_ADDR_REQ = 4'h0;   // request register
    localparam logic [3:0] IPM_ADDR_MASK = 4'h1;  // mask register
    localparam logic [3:0] IPM_ADDR_PRIO = 4'h2;  // priority register
    localparam logic [3:0] IPM_ADDR_REC1 = 4'h3;  // first recovery register
    localparam logic [3:0] IPM_ADDR_REC2 = 4'h4;  // second recovery register
    localparam logic [3:0] IPM_ADDR_STAT = 4'h5;  // mode status
    // field positions
    localparam int IPM_EDGE_L1_BIT = 7;           // request register D7: line one edge
    localparam int IPM_EDGE_L2_BIT = 6;           // request register D6: line two edge
    localparam int IPM_GLOBAL_BIT = 7;            // mask register global enable
    localparam int IPM_STOP_DLY_BIT = 5;          // first recovery register D5
    localparam int IPM_SRC_LO_BIT = 2;            // first recovery source D4..D2
    // reset values
    localparam logic [7:0] IPM_REQ_RST = 8'h00;
    localparam logic [7:0] IPM_MASK_RST = 8'h00;
    localparam logic [7:0] IPM_PRIO_RST = 8'h00;
    localparam logic [7:0] IPM_REC1_RST = 8'h20;  // stop delay on
    localparam logic [7:0] IPM_REC2_RST = 8'h00;
    // opcodes
    localparam logic [7:0] IPM_OP_NOP = 8'hFF;
    localparam logic [7:0] IPM_OP_STOP = 8'h6F;
    localparam logic [7:0] IPM_OP_HALT = 8'h7F;
    // one-shot reset delay
    localparam int IPM_POR_NS = 1000;
    localparam int IPM_CLK_NS = 8;
    localparam int IPM_POR_CYC = (IPM_POR_NS + IPM_CLK_NS - 1) / IPM_CLK_NS;
    localparam int IPM_NREQ = 6;

    typedef enum logic [1:0] {
        IPM_RUN = 2'b00,
        IPM_HALT = 2'b01,
        IPM_STOP = 2'b10,
        IPM_HOLD = 2'b11
    } ipm_mode_t;

    // grant to the core: vector address and one-hot source
    typedef struct packed {
        logic valid;
        logic [15:0] vec_addr;
        logic [5:0] src;
    } ipm_grant_t;

    // reset causes
    typedef struct packed {
        logic power_good;
        logic watchdog;
        logic low_voltage;
        logic external;
    } ipm_rst_src_t;
endpackage : ipm_pkg

// >>> dv/ipm_core_model.sv
/*
 * ipm_core_model: behavioural processor core facing the grant port.
 * assumes one mclk domain; waits ack_wait cycles before acknowledging.
 */
`timescale 1ns/1ps
module ipm_core_model
    import ipm_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // grant side
    input ipm_pkg::ipm_grant_t grant,
    input wire logic [3:0] ack_wait,
    output logic grant_ack,
    output logic int_reenable
);
    logic [1:0] st_r;
    logic [3:0] cnt_r;

    // ack after a chosen delay, then re-enable like a return from service
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_r <= 2'h0;
            cnt_r <= 4'h0;
            grant_ack <= 1'b0;
            int_reenable <= 1'b0;
        end else begin
            grant_ack <= 1'b0;
            int_reenable <= 1'b0;
            case (st_r)
                2'h0: if (grant.valid === 1'b1) begin
                    cnt_r <= ack_wait;
                    st_r <= 2'h1;
                end
                2'h1: if (cnt_r == 4'h0) begin
                    grant_ack <= 1'b1; // one pulse, grant held until here
                    st_r <= 2'h2;
                end else begin
                    cnt_r <= cnt_r - 4'h1;
                end
                2'h2: st_r <= 2'h3; // let valid drop before looking again
                default: begin
                    int_reenable <= 1'b1;
                    st_r <= 2'h0;
                end
            endcase
        end
    end
endmodule : ipm_core_model

// >>> dv/tb.sv
/*
 * tb: self-checking bench for ipm_ctrl with a core model on the grant port.
 * assumes pins are synchronous levels and a short reset delay parameter.
 */
`timescale 1ns/1ps
module tb;
    import ipm_pkg::*;
    localparam int POR_C = 12; // short delay keeps the run brief
    logic mclk, rst, reg_wr, reg_rd, op_valid, t0, t1, an1, an2, amode, perm, rcclk, wstop, vd, rdd;
    logic grant_ack, int_reenable, save_context, cpu_clk_en, osc_en, comparator_en, cpu_run, restart, watchdog_run;
    logic [3:0] reg_addr, p3, ack_w;
    logic [7:0] reg_wdata, rec_l, op_code, reg_rdata;
    ipm_rst_src_t rs;
    ipm_grant_t grant;
    int n_errors, compares, ngr, seed, e, c, k;
    int gq[$];
    logic [7:0] rq[$];

    ipm_ctrl #(.POR_CYCLES(POR_C)) dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .port3_line0(p3[0]), .port3_line1(p3[1]),
        .port3_line2(p3[2]), .port3_line3(p3[3]), .timer_zero_end(t0), .timer_one_end(t1),
        .first_analog_comparator(an1), .second_analog_comparator(an2), .analog_mode(amode),
        .recovery_lines(rec_l), .rst_src(rs), .permanent_watchdog(perm), .watchdog_rc_clock(rcclk),
        .watchdog_stop_req(wstop), .op_code(op_code), .op_valid(op_valid), .grant_ack(grant_ack),
        .int_reenable(int_reenable), .grant(grant), .save_context(save_context), .cpu_clk_en(cpu_clk_en),
        .osc_en(osc_en), .comparator_en(comparator_en), .cpu_run(cpu_run), .restart(restart),
        .watchdog_run(watchdog_run));
    ipm_core_model core (.mclk(mclk), .rst(rst), .grant(grant), .ack_wait(ack_w), .grant_ack(grant_ack),
        .int_reenable(int_reenable));

    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error %s: expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task end_sim;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : end_sim

    task cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask : cyc

    // bus cycles: strobe one cycle, then released on the following edge
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : wr

    task rd(input logic [3:0] a, input logic [7:0] x);
        rq.push_back(x);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
    endtask : rd

    task op(input logic [7:0] o);
        @(posedge mclk);
        op_code <= o;
        op_valid <= 1'b1;
        @(posedge mclk);
        op_valid <= 1'b0;
    endtask : op

    task pin(input int i, input logic v);
        @(posedge mclk);
        p3[i] <= v;
        cyc(3);
    endtask : pin

    task tpulse(input logic w);
        @(posedge mclk);
        t0 <= !w;
        t1 <= w;
        @(posedge mclk);
        t0 <= 1'b0;
        t1 <= 1'b0;
        cyc(3);
    endtask : tpulse

    // one qualifying event for source n; falling lines return high untriggered
    task fire(input int n);
        case (n)
            0: pin(2, !p3[2]);
            1: begin pin(3, 1'b0); pin(3, 1'b1); end
            2: pin(1, !p3[1]);
            3: begin pin(0, 1'b0); pin(0, 1'b1); end
            4: tpulse(1'b0);
            default: tpulse(1'b1);
        endcase
    endtask : fire

    task wait_g(input int n);
        c = 0;
        while (ngr < n && c < 300) begin
            @(posedge mclk);
            c++;
        end
        if (c >= 300) begin
            n_errors++;
            $display("Error grant wait: expected %0d seen %0d", n, ngr);
            end_sim();
        end
    endtask : wait_g

    // stop, wake by recovery line or watchdog, measure the hold-off
    task stop_exit(input logic [7:0] r1, input logic wd, input logic longx);
        wr(IPM_ADDR_REC1, r1);
        op(IPM_OP_NOP);
        op(IPM_OP_STOP);
        cyc(3);
        check("osc_en", osc_en, 1'b0);
        check("comparator_en", comparator_en, 1'b0);
        @(posedge mclk);
        if (wd) rs.watchdog <= 1'b1;
        else rec_l[1] <= 1'b1;
        @(posedge mclk);
        rs.watchdog <= 1'b0;
        rec_l[1] <= 1'b0;
        c = 0;
        while (restart !== 1'b1 && c < 100) begin
            @(posedge mclk);
            c++;
        end
        check("restart", restart, 1'b1);
        check("stop_delay", c >= POR_C - 2, longx);
        cyc(3);
        check("cpu_run", cpu_run, 1'b1);
        check("osc_en", osc_en, 1'b1);
    endtask : stop_exit

    // watcher: read data one cycle after the strobe, grants against notes
    always @(posedge mclk) begin
        if (rst) begin
            vd <= 1'b0;
            rdd <= 1'b0;
        end else begin
            rdd <= reg_rd;
            vd <= grant.valid;
            if (rdd) check("reg_rdata", reg_rdata, rq.pop_front());
            if (grant.valid === 1'b1 && vd !== 1'b1) begin
                ngr++;
                if (gq.size() == 0) check("grant_unexpected", 1'b1, 1'b0);
                else begin
                    e = gq.pop_front();
                    check("vec_addr", grant.vec_addr, 16'(2 * e));
                    check("src", grant.src, 16'(1 << e));
                    check("save_context", save_context, 1'b1);
                end
            end
        end
    end

    initial begin
        {reg_wr, reg_rd, op_valid, t0, t1, an1, an2, amode, perm, rcclk, wstop} = '0;
        {reg_addr, reg_wdata, rec_l, op_code, rs, ack_w} = '0;
        p3 = 4'hF;
        rst = 1'b1;
        seed = 58995;
        cyc(6);
        check("cpu_run_rst", cpu_run, 1'b0);
        rst <= 1'b0;
        c = 0;
        while (cpu_run !== 1'b1 && c < 100) begin
            @(posedge mclk);
            c++;
        end
        check("por_hold", c >= POR_C, 1'b1);
        rd(IPM_ADDR_REQ, IPM_REQ_RST);
        rd(IPM_ADDR_MASK, IPM_MASK_RST);
        rd(IPM_ADDR_PRIO, IPM_PRIO_RST);
        rd(IPM_ADDR_REC1, 8'h20);
        rd(IPM_ADDR_REC2, IPM_REC2_RST);
        rd(4'hF, 8'h00);
        rd(IPM_ADDR_STAT, {5'h00, 1'b1, IPM_RUN});
        // masked source still recorded for polling
        wr(IPM_ADDR_REQ, 8'hC0);
        fire(3);
        rd(IPM_ADDR_REQ, 8'hC8);
        // edge select table on lines one and two, two toggles each
        for (int s = 0; s < 4; s++) begin
            for (int t = 0; t < 2; t++) begin
                wr(IPM_ADDR_REQ, {2'(s), 6'h00});
                pin(1, !p3[1]);
                pin(2, !p3[2]);
                rd(IPM_ADDR_REQ, {2'(s), 3'h0, (p3[1] ? s[1] : (!s[1] || s[0])), 1'b0,
                    (p3[2] ? s[0] : (!s[0] || s[1]))});
            end
        end
        // analog mode remaps comparators and recovery source
        wr(IPM_ADDR_REC1, 8'h28);
        wr(IPM_ADDR_REQ, 8'hC0);
        amode <= 1'b1;
        an1 <= 1'b1;
        an2 <= 1'b1;
        rec_l[2] <= 1'b1;
        cyc(3);
        // sources sit high in analog mode, so the drop is the event
        {an1, an2} <= 2'h0;
        rec_l[2] <= 1'b0;
        cyc(4);
        rd(IPM_ADDR_REQ, 8'hC7);
        amode <= 1'b0;
        cyc(4);
        wr(IPM_ADDR_REQ, 8'hC0);
        // each source vectors alone, with a random ack delay
        wr(IPM_ADDR_MASK, 8'hBF);
        for (int n = 0; n < 6; n++) begin
            ack_w <= 4'($random(seed) & 7);
            gq.push_back(n);
            fire(n);
            wait_g(n + 1);
        end
        cyc(8);
        rd(IPM_ADDR_REQ, 8'hC0);
        // three pending at once, ordered from a random start index
        wr(IPM_ADDR_MASK, 8'h3F);
        fire(3);
        fire(4);
        fire(5);
        k = {$random(seed)} % 6;
        wr(IPM_ADDR_PRIO, 8'(k));
        for (int i = 0; i < 6; i++) if ((k + i) % 6 >= 3) gq.push_back((k + i) % 6);
        wr(IPM_ADDR_MASK, 8'hBF);
        wait_g(9);
        // sleep opcode without the flush is refused; with it, halt
        op(8'h00);
        op(IPM_OP_HALT);
        cyc(3);
        check("cpu_clk_en", cpu_clk_en, 1'b1);
        op(IPM_OP_NOP);
        op(IPM_OP_HALT);
        cyc(3);
        check("cpu_clk_en", cpu_clk_en, 1'b0);
        check("osc_en", osc_en, 1'b1);
        check("comparator_en", comparator_en, 1'b1);
        gq.push_back(4);
        fire(4);
        wait_g(10);
        cyc(8);
        check("cpu_clk_en", cpu_clk_en, 1'b1);
        stop_exit(8'h24, 1'b0, 1'b1);
        stop_exit(8'h04, 1'b0, 1'b0);
        stop_exit(8'h04, 1'b1, 1'b1);
        {perm, rcclk, wstop} <= 3'h7;
        cyc(4);
        check("watchdog_run", watchdog_run, 1'b1);
        {perm, rcclk} <= 2'h0;
        cyc(4);
        check("watchdog_stop", watchdog_run, 1'b0);
        end_sim();
    end
endmodule : tb
